// File: rtl/tps_pkg.sv
// Operation
// - Results are unsigned, split over two 8-bit result registers read serially.
// - Reference control selects internal 1.25 V or 2.5 V, or external.
// - Touch coordinate conversions are always ratiometric, whatever reference.
// - Converter control one bits 6..5 select 8, 10 or 12 bit resolution.
// - Clock select bit 7 picks internal oscillator or master clock.
// - Converter control one bits 4..3 divide the selected clock.
// - Oscillator runs at nominal 8.2 MHz; sequencing intervals count ticks of the selected clock.
// - Pin function code 1100 in bits 5..2 makes pin the interrupt.
// - Interrupt shows pen touch by default, else data-ready or both.
// - Idle: Y-minus grounded, X-plus pulled up and buffered to interrupt.
// - X-plus pull-up is disconnected during X and Y measurement.
// - Pen debounce runs from oscillator or master clock.
// - Touch re-check restores detect drivers, pull-up, precharge before sensing.
// - Precharge, sense and stabilization times come from timing registers.
// - Timing register bit 7 disables pen-touch detection.
// - Converter control two bit 7 picks host or self-controlled conversion.
// - Self mode: on touch, interrupt, clock start, Y drive, stabilize, convert.
// - If still touched, drive X, stabilize, convert, store X result.
// - Self mode repeats scans until touch removed or converter powered down.
// - Host mode: interrupt on touch, host writes scan function, device sequences.
// - Converter control one bit 7 forces converter power-down.
// - Self mode waits the interval timer before re-checking touch.
package tps_pkg;
    // Register offsets, page select lives at offset 0 of every page
    localparam logic [6:0] OFS_PAGE = 7'h00;
    localparam logic [6:0] OFS_CONV_ONE = 7'h02;
    localparam logic [6:0] OFS_CONV_TWO = 7'h03;
    localparam logic [6:0] OFS_PRE_SENSE = 7'h04;
    localparam logic [6:0] OFS_STAB = 7'h05;
    localparam logic [6:0] OFS_REF = 7'h06;
    localparam logic [6:0] OFS_CLK_SRC = 7'h10;
    localparam logic [6:0] OFS_CLK_COMP = 7'h11;
    localparam logic [6:0] OFS_RES_X_HI = 7'h2A;
    localparam logic [6:0] OFS_RES_X_LO = 7'h2B;
    localparam logic [6:0] OFS_RES_Y_HI = 7'h2C;
    localparam logic [6:0] OFS_RES_Y_LO = 7'h2D;
    localparam logic [6:0] OFS_PIN_ONE = 7'h33;
    localparam logic [6:0] OFS_PIN_TWO = 7'h34;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_THREE = 8'h03;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int BIT_PWDN = 7;
    localparam int RES_HI = 6;
    localparam int RES_LO = 5;
    localparam int DIV_HI = 4;
    localparam int DIV_LO = 3;
    localparam int BIT_SELF = 7;
    localparam int FN_HI = 5;
    localparam int FN_LO = 2;
    localparam int IRQ_HI = 1;
    localparam int IRQ_LO = 0;
    localparam int BIT_PEN_OFF = 7;
    localparam int PRE_HI = 6;
    localparam int PRE_LO = 4;
    localparam int SNS_HI = 2;
    localparam int SNS_LO = 0;
    localparam int BIT_CLK_SEL = 7;
    localparam int BIT_REF_EXT = 2;
    localparam int BIT_REF_HI = 1;
    // Encodings
    localparam logic [3:0] PIN_FN_IRQ = 4'b1100;
    localparam logic [3:0] SCAN_XY = 4'b0001;
    localparam logic [3:0] SCAN_NONE = 4'b0000;
    localparam logic [1:0] IRQ_PEN = 2'b00;
    localparam logic [1:0] IRQ_DATA = 2'b01;
    localparam logic [1:0] IRQ_BOTH = 2'b10;
    localparam logic [1:0] RES_8 = 2'b01;
    localparam logic [1:0] RES_10 = 2'b10;
    localparam logic [3:0] LSB_8 = 4'h4;
    localparam logic [3:0] LSB_10 = 4'h2;
    localparam logic [3:0] LSB_12 = 4'h0;
    localparam logic [3:0] MSB_IDX = 4'hB;
    localparam logic [3:0] SPI_LAST = 4'hF;
    localparam logic [3:0] SPI_ADDR_DONE = 4'h7;
    localparam logic [3:0] SPI_DATA_FIRST = 4'h8;
    // Timing
    localparam longint CORE_HZ = 200_000_000;
    localparam longint OSC_HZ = 8_200_000;
    localparam int OSC_DIV = int'(CORE_HZ / OSC_HZ);
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    typedef enum logic [3:0] {
        ST_DETECT = 4'b0000,
        ST_PRECHARGE = 4'b0001,
        ST_SENSE = 4'b0010,
        ST_YSTAB = 4'b0011,
        ST_YCONV = 4'b0100,
        ST_XSTAB = 4'b0101,
        ST_XCONV = 4'b0110,
        ST_INTERVAL = 4'b0111
    } tps_state_e;

    typedef struct packed {
        logic yMinusToGround;
        logic xPlusPullup;
        logic precharge;
        logic yDrive;
        logic xDrive;
        logic sarPower;
        logic ratiometric;
    } tps_panel_s;
endpackage

// File: rtl/tps_sequencer.sv
`timescale 1ns/100ps
module tps_sequencer
    import tps_pkg::*;
#(
    parameter int PRE_UNIT = 4,
    parameter int SNS_UNIT = 4,
    parameter int STAB_UNIT = 8,
    parameter int DEB_TICKS = 16,
    parameter int INTERVAL_TICKS = 4096
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Serial control port
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOeN,
    // Master clock, sampled as a level
    input wire logic masterClk,
    // Panel sense and converter comparator
    input wire logic penSenseN,
    input wire logic compHigh,
    output logic [11:0] dacCode,
    output tps_panel_s panel,
    // Reference steering
    output logic refUseInternal,
    output logic refLevelHigh,
    // General pins
    output logic generalPinOne,
    output logic generalPinOneOeN,
    output logic generalPinTwo,
    output logic generalPinTwoOeN
);

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] pageSel, convOne, convTwo, preSense, stabReg, refCtl;
    logic [7:0] clkSrc, clkComp, pinOneFn, pinTwoFn;
    logic [11:0] resX, resY;
    logic dataReady;

    // Serial port state
    logic sclkQ, sclkRise, sclkFall;
    logic [3:0] bitCnt;
    logic [6:0] spiAddr;
    logic spiRead;
    logic [7:0] rxShift, txShift;
    logic wrStrobe;
    logic [7:0] wrData;
    logic [6:0] wrAddr;
    logic rdLoad;
    logic [7:0] rdData;
    logic [7:0] rxByte;

    // Edge detection on the serial clock
    assign sclkRise = spiSclk & ~sclkQ;
    assign sclkFall = ~spiSclk & sclkQ;
    assign rxByte = {rxShift[6:0], spiMosi};
    assign spiMiso = txShift[7];
    assign spiMisoOeN = spiCsN | ~spiRead | (bitCnt < SPI_DATA_FIRST);

    // Serial shifting: address byte with read flag, then data bytes
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclkQ <= 1'b0;
            bitCnt <= 4'h0;
            spiAddr <= 7'h00;
            spiRead <= 1'b0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
        end else begin
            sclkQ <= spiSclk;
            if (spiCsN) begin
                bitCnt <= 4'h0;
                spiRead <= 1'b0;
            end else if (sclkRise) begin
                rxShift <= rxByte;
                bitCnt <= (bitCnt == SPI_LAST) ? SPI_DATA_FIRST
                                               : bitCnt + 4'h1;
                if (bitCnt == SPI_ADDR_DONE) begin
                    spiAddr <= rxByte[7:1];
                    spiRead <= rxByte[0];
                end
                if (bitCnt == SPI_LAST) begin
                    spiAddr <= spiAddr + 7'h01;
                end
            end else if (sclkFall && bitCnt > SPI_DATA_FIRST) begin
                txShift <= {txShift[6:0], 1'b0};
            end else if (rdLoad) begin
                txShift <= rdData;
            end
        end
    end

    // Write commit at the last data bit; read data loaded one cycle later
    assign wrStrobe = ~spiCsN & sclkRise & ~spiRead & (bitCnt == SPI_LAST);
    assign wrData = rxByte;
    assign wrAddr = spiAddr;

    logic rdLoadQ;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdLoadQ <= 1'b0;
        end else begin
            rdLoadQ <= ~spiCsN & sclkRise &
                       ((bitCnt == SPI_ADDR_DONE & rxByte[0]) |
                        (bitCnt == SPI_LAST & spiRead));
        end
    end
    assign rdLoad = rdLoadQ;

    // Register decode
    logic onP0, onP3, wrP0, wrP3;
    assign onP0 = pageSel == PAGE_ZERO;
    assign onP3 = pageSel == PAGE_THREE;
    assign wrP0 = wrStrobe & onP0;
    assign wrP3 = wrStrobe & onP3;

    // Read mux, results right-justified and unsigned
    always_comb begin
        rdData = 8'h00;
        if (spiAddr == OFS_PAGE) begin
            rdData = pageSel;
        end else if (onP0) begin
            case (spiAddr)
                OFS_PIN_ONE: rdData = pinOneFn;
                OFS_PIN_TWO: rdData = pinTwoFn;
                default: rdData = 8'h00;
            endcase
        end else if (onP3) begin
            case (spiAddr)
                OFS_CONV_ONE: rdData = convOne;
                OFS_CONV_TWO: rdData = convTwo;
                OFS_PRE_SENSE: rdData = preSense;
                OFS_STAB: rdData = stabReg;
                OFS_REF: rdData = refCtl;
                OFS_CLK_SRC: rdData = clkSrc;
                OFS_CLK_COMP: rdData = clkComp;
                OFS_RES_X_HI: rdData = {4'h0, resX[11:8]};
                OFS_RES_X_LO: rdData = resX[7:0];
                OFS_RES_Y_HI: rdData = {4'h0, resY[11:8]};
                OFS_RES_Y_LO: rdData = resY[7:0];
                default: rdData = 8'h00;
            endcase
        end
    end

    // Configuration register storage
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pageSel <= REG_RESET;
            convOne <= REG_RESET;
            preSense <= REG_RESET;
            stabReg <= REG_RESET;
            refCtl <= REG_RESET;
            clkSrc <= REG_RESET;
            clkComp <= REG_RESET;
            pinOneFn <= REG_RESET;
            pinTwoFn <= REG_RESET;
        end else if (wrStrobe) begin
            if (wrAddr == OFS_PAGE) pageSel <= wrData;
            if (wrP0 && wrAddr == OFS_PIN_ONE) pinOneFn <= wrData;
            if (wrP0 && wrAddr == OFS_PIN_TWO) pinTwoFn <= wrData;
            if (wrP3 && wrAddr == OFS_CONV_ONE) convOne <= wrData;
            if (wrP3 && wrAddr == OFS_PRE_SENSE) preSense <= wrData;
            if (wrP3 && wrAddr == OFS_STAB) stabReg <= wrData;
            if (wrP3 && wrAddr == OFS_REF) refCtl <= wrData;
            if (wrP3 && wrAddr == OFS_CLK_SRC) clkSrc <= wrData;
            if (wrP3 && wrAddr == OFS_CLK_COMP) clkComp <= wrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock source and converter clock
    logic [5:0] oscCnt;
    logic oscTick, mclkQ, mclkTick, seqTick;
    logic [2:0] divCnt;
    logic convTick;
    logic [2:0] divMask;

    // Oscillator enable at nominal 8.2 MHz
    assign oscTick = oscCnt == 6'(OSC_DIV - 1);
    assign mclkTick = masterClk & ~mclkQ;
    // Source select for sequencer and debounce
    assign seqTick = clkSrc[BIT_CLK_SEL] ? mclkTick : oscTick;
    // Ratio 1, 2, 4 or 8 from the divide field
    assign divMask = 3'((4'h1 << convOne[DIV_HI:DIV_LO]) - 4'h1);
    assign convTick = seqTick & ((divCnt & divMask) == divMask);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oscCnt <= 6'h00;
            mclkQ <= 1'b0;
            divCnt <= 3'h0;
        end else begin
            oscCnt <= oscTick ? 6'h00 : oscCnt + 6'h01;
            mclkQ <= masterClk;
            if (seqTick) divCnt <= divCnt + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    tps_state_e state, next_state;
    logic [15:0] tmr, next_tmr;
    logic nextIsX, next_nextIsX;
    logic hostReq;
    logic penOn, penRaw, penDeb;
    logic [7:0] debCnt;
    logic pwdn, selfMode, detOff, tmrDone, scanWrite;
    logic [15:0] preTicks, snsTicks, stabTicks;
    logic [3:0] sarIdx, lsbIdx;
    logic [11:0] sarCode, trial;
    logic convState, sarLast, stillTouched, startScan;

    assign pwdn = convOne[BIT_PWDN];
    assign selfMode = convTwo[BIT_SELF];
    assign detOff = preSense[BIT_PEN_OFF];
    assign preTicks = 16'(PRE_UNIT * (preSense[PRE_HI:PRE_LO] + 1));
    assign snsTicks = 16'(SNS_UNIT * (preSense[SNS_HI:SNS_LO] + 1));
    assign stabTicks = 16'(STAB_UNIT * (stabReg[SNS_HI:SNS_LO] + 1));
    assign tmrDone = tmr == CNT_ZERO;
    assign scanWrite = wrP3 & (wrAddr == OFS_CONV_TWO) &
                       (wrData[FN_HI:FN_LO] == SCAN_XY);
    assign stillTouched = ~penSenseN & ~detOff;
    // Self mode starts on touch; host mode waits for a scan write
    assign startScan = selfMode | hostReq;

    // Pull-up only in detect phases, never while measuring
    assign penOn = (state == ST_DETECT) | (state == ST_PRECHARGE) |
                   (state == ST_SENSE);
    assign penRaw = ~penSenseN & ~detOff;

    // Pen debounce, frozen while the pull-up is off
    // A failed re-check drops the stale pen so scans stop
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            debCnt <= 8'h00;
            penDeb <= 1'b0;
        end else if (detOff ||
                     (state == ST_SENSE && next_state == ST_DETECT)) begin
            debCnt <= 8'h00;
            penDeb <= 1'b0;
        end else if (seqTick && state == ST_DETECT) begin
            if (penRaw == penDeb) begin
                debCnt <= 8'h00;
            end else if (debCnt == 8'(DEB_TICKS - 1)) begin
                debCnt <= 8'h00;
                penDeb <= penRaw;
            end else begin
                debCnt <= debCnt + 8'h01;
            end
        end
    end

    // Resolution picks the last bit to resolve
    assign lsbIdx = (convOne[RES_HI:RES_LO] == RES_8) ? LSB_8 :
                    (convOne[RES_HI:RES_LO] == RES_10) ? LSB_10 : LSB_12;
    assign convState = (state == ST_YCONV) | (state == ST_XCONV);
    assign trial = sarCode | (12'h001 << sarIdx);
    assign sarLast = convTick & (sarIdx == lsbIdx);
    assign dacCode = trial;

    // Next-state logic
    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_nextIsX = nextIsX;
        if (seqTick && !tmrDone) next_tmr = tmr - CNT_ONE;
        case (state)
            ST_DETECT: begin
                next_nextIsX = 1'b0;
                if (penDeb && startScan && !pwdn) begin
                    next_state = ST_YSTAB;
                    next_tmr = stabTicks;
                end
            end
            ST_PRECHARGE: begin
                if (tmrDone) begin
                    next_state = ST_SENSE;
                    next_tmr = snsTicks;
                end
            end
            ST_SENSE: begin
                if (tmrDone) begin
                    if (stillTouched) begin
                        next_state = nextIsX ? ST_XSTAB : ST_YSTAB;
                        next_tmr = stabTicks;
                    end else begin
                        next_state = ST_DETECT;
                    end
                end
            end
            ST_YSTAB: begin
                if (tmrDone) next_state = ST_YCONV;
            end
            ST_YCONV: begin
                if (sarLast) begin
                    next_state = ST_PRECHARGE;
                    next_tmr = preTicks;
                    next_nextIsX = 1'b1;
                end
            end
            ST_XSTAB: begin
                if (tmrDone) next_state = ST_XCONV;
            end
            ST_XCONV: begin
                if (sarLast) begin
                    next_state = ST_INTERVAL;
                    next_tmr = 16'(INTERVAL_TICKS);
                    next_nextIsX = 1'b0;
                end
            end
            ST_INTERVAL: begin
                if (tmrDone) begin
                    next_state = ST_PRECHARGE;
                    next_tmr = preTicks;
                end
            end
            default: next_state = ST_DETECT;
        endcase
        // Forced power-down or disabled detection stops any scan
        if (pwdn || detOff) begin
            next_state = ST_DETECT;
            next_tmr = CNT_ZERO;
        end
    end

    // State, scan request and converter registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_DETECT;
            tmr <= CNT_ZERO;
            nextIsX <= 1'b0;
            hostReq <= 1'b0;
            convTwo <= REG_RESET;
            sarIdx <= MSB_IDX;
            sarCode <= 12'h000;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            nextIsX <= next_nextIsX;
            if (wrP3 && wrAddr == OFS_CONV_TWO) convTwo <= wrData;
            // Host scan stands until a re-check finds no touch or power-down is forced
            if (scanWrite) begin
                hostReq <= 1'b1;
            end else if (state == ST_SENSE && next_state == ST_DETECT) begin
                hostReq <= 1'b0;
            end else if (pwdn) begin
                hostReq <= 1'b0;
            end
            if (!convState) begin
                sarIdx <= MSB_IDX;
                sarCode <= 12'h000;
            end else if (convTick) begin
                if (compHigh) sarCode <= trial;
                sarIdx <= sarIdx - 4'h1;
            end
        end
    end

    // Result capture and data-ready flag, set wins over read clear
    logic [11:0] finalCode, justified;
    logic resRead;
    assign finalCode = compHigh ? trial : sarCode;
    assign justified = finalCode >> lsbIdx;
    assign resRead = rdLoad & onP3 &
                     ((spiAddr == OFS_RES_X_LO) | (spiAddr == OFS_RES_Y_LO));

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resX <= 12'h000;
            resY <= 12'h000;
            dataReady <= 1'b0;
        end else begin
            if (sarLast && state == ST_YCONV) resY <= justified;
            if (sarLast && state == ST_XCONV) resX <= justified;
            if (sarLast && state == ST_XCONV) begin
                dataReady <= 1'b1;
            end else if (resRead) begin
                dataReady <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel drivers and reference
    always_comb begin
        panel.yMinusToGround = penOn | (state == ST_YSTAB) |
                               (state == ST_YCONV);
        panel.xPlusPullup = penOn;
        panel.precharge = state == ST_PRECHARGE;
        panel.yDrive = (state == ST_YSTAB) | (state == ST_YCONV);
        panel.xDrive = (state == ST_XSTAB) | (state == ST_XCONV);
        panel.sarPower = convState & ~pwdn;
        panel.ratiometric = 1'b1;
    end

    assign refUseInternal = ~refCtl[BIT_REF_EXT];
    assign refLevelHigh = refCtl[BIT_REF_HI];

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pins, active low
    logic irqLevelN;
    logic pinOneIrq, pinTwoIrq;

    // Source select: pen, data-ready or either
    always_comb begin
        case (convTwo[IRQ_HI:IRQ_LO])
            IRQ_DATA: irqLevelN = ~dataReady;
            IRQ_BOTH: irqLevelN = ~(penDeb | dataReady);
            default: irqLevelN = ~penDeb;
        endcase
    end

    assign pinOneIrq = pinOneFn[FN_HI:FN_LO] == PIN_FN_IRQ;
    assign pinTwoIrq = pinTwoFn[FN_HI:FN_LO] == PIN_FN_IRQ;
    assign generalPinOne = pinOneIrq ? irqLevelN : 1'b1;
    assign generalPinOneOeN = ~pinOneIrq;
    assign generalPinTwo = pinTwoIrq ? irqLevelN : 1'b1;
    assign generalPinTwoOeN = ~pinTwoIrq;

endmodule

// File: verif/tps_sequencer_sva.sv
`timescale 1ns/100ps
module tps_sequencer_sva
    import tps_pkg::*;
(
    // Clock, reset and watched outputs
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic spiCsN,
    input wire logic spiMisoOeN,
    input wire tps_panel_s panel,
    input wire logic generalPinOne,
    input wire logic generalPinOneOeN,
    input wire logic generalPinTwo,
    input wire logic generalPinTwoOeN
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // Panel driven along either axis
    wire drv = panel.xDrive | panel.yDrive;
    AST_PULL_OFF:
        assert property (drv |-> !panel.xPlusPullup) else $error("pullup on");
    AST_RATIO:
        assert property (drv |-> panel.ratiometric) else $error("not ratio");
    AST_ONE_AXIS:
        assert property (!(panel.xDrive && panel.yDrive)) else $error("x and y");
    AST_PRECHG:
        assert property (panel.precharge |-> panel.xPlusPullup && !drv)
        else $error("precharge bad");
    AST_SAR_UP:
        assert property ($rose(panel.sarPower) |-> drv) else $error("sar idle");
    AST_PIN_ONE:
        assert property (generalPinOneOeN |-> generalPinOne)
        else $error("pin one low");
    AST_PIN_TWO:
        assert property (generalPinTwoOeN |-> generalPinTwo)
        else $error("pin two low");
    AST_MISO_IDLE:
        assert property (spiCsN [*2] |-> spiMisoOeN) else $error("miso driven");
endmodule

// File: verif/tps_panel_model.sv
`timescale 1ns/100ps
module tps_panel_model
    import tps_pkg::*;
(
    // Clock and panel state
    input wire logic core_clk,
    input wire tps_panel_s panel,
    input wire logic [11:0] dacCode,
    // Touch and position
    input wire logic touched,
    input wire logic [11:0] xPos,
    input wire logic [11:0] yPos,
    // Sense and comparator
    output logic penSenseN,
    output logic compHigh
);
    logic wobble = 1'b0;
    ////////////////////////////////////////////////////////////
    // Undriven nodes wander, so nothing is read from a stale level
    always @(posedge core_clk) wobble <= ~wobble;
    // Touch shorts the pulled-up X-plus to grounded Y-minus
    assign penSenseN = panel.xPlusPullup ?
        !(touched && panel.yMinusToGround) : wobble;
    // Divider voltage on the driven axis against the trial code
    assign compHigh = panel.yDrive ? (yPos >= dacCode) :
        panel.xDrive ? (xPos >= dacCode) : wobble;
endmodule

// File: verif/tb.sv
`timescale 1ns/100ps
module tb
    import tps_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic spiSclk = 1'b0;
    logic spiCsN = 1'b1;
    logic spiMosi = 1'b0;
    logic masterClk = 1'b0;
    logic touched = 1'b0;
    logic [11:0] xPos = 12'h000;
    logic [11:0] yPos = 12'h000;
    logic spiMiso, spiMisoOeN, penSenseN, compHigh;
    logic refUseInternal, refLevelHigh;
    logic generalPinOne, generalPinOneOeN, generalPinTwo, generalPinTwoOeN;
    logic [11:0] dacCode;
    tps_panel_s panel;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    wire [1:0] refPins = {refUseInternal, refLevelHigh};
    tps_sequencer #(.PRE_UNIT(1), .SNS_UNIT(1), .STAB_UNIT(1),
        .DEB_TICKS(2), .INTERVAL_TICKS(8)) i_tps_sequencer (
        .core_clk(core_clk), .sys_rst(sys_rst), .spiSclk(spiSclk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .spiMisoOeN(spiMisoOeN), .masterClk(masterClk),
        .penSenseN(penSenseN), .compHigh(compHigh), .dacCode(dacCode),
        .panel(panel), .refUseInternal(refUseInternal),
        .refLevelHigh(refLevelHigh), .generalPinOne(generalPinOne),
        .generalPinOneOeN(generalPinOneOeN), .generalPinTwo(generalPinTwo),
        .generalPinTwoOeN(generalPinTwoOeN));
    tps_panel_model i_tps_panel_model (.core_clk(core_clk), .panel(panel),
        .dacCode(dacCode), .touched(touched), .xPos(xPos), .yPos(yPos),
        .penSenseN(penSenseN), .compHigh(compHigh));
    ////////////////////////////////////////////////////////////
    // Core clock, master clock, hang guard
    always #2.5 core_clk = ~core_clk;
    always #50 masterClk = ~masterClk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude;
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected %0t got %h want %h", $time, seen, want);
        end
    endtask
    // Serial frame, mode 0, half period of five clocks
    task automatic xfer(input logic [6:0] a, input logic rd,
        input logic [7:0] wd, output logic [7:0] q);
        logic [15:0] sh;
        sh = {a, rd, wd};
        q = 8'h00;
        spiCsN = 1'b0;
        for (int i = 0; i < 16; i++) begin
            spiMosi = sh[15 - i];
            repeat (5) @(negedge core_clk);
            if (i > 7) q = {q[6:0], spiMiso};
            spiSclk = 1'b1;
            repeat (5) @(negedge core_clk);
            spiSclk = 1'b0;
        end
        repeat (5) @(negedge core_clk);
        spiCsN = 1'b1;
        repeat (5) @(negedge core_clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(a, 1'b0, d, q);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(a, 1'b1, 8'h00, q);
        chk({4'h0, q}, {4'h0, e});
    endtask
    // Bounded wait for an axis driver to reach a level
    task automatic wait_drive(input logic onX, input logic lvl);
        int n = 0;
        while ((onX ? panel.xDrive : panel.yDrive) !== lvl && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        chk({11'h0, onX ? panel.xDrive : panel.yDrive}, {11'h0, lvl});
    endtask
    task automatic t_regs;
        logic [7:0] v;
        wr(OFS_PAGE, PAGE_THREE);
        rdc(OFS_CONV_TWO, REG_RESET);
        wr(OFS_STAB, 8'h05);
        rdc(OFS_STAB, 8'h05);
        wr(7'h7F, 8'hFF);
        rdc(7'h7F, 8'h00);
        for (int k = 0; k < 3; k++) begin
            v = {5'h00, k[1:0], 1'b0};
            wr(OFS_REF, v);
            chk({10'h0, refPins}, {10'h0, ~v[2], v[1]});
        end
    endtask
    task automatic t_self;
        wr(OFS_CLK_SRC, 8'h80);
        wr(OFS_CLK_COMP, 8'h80);
        wr(OFS_CONV_ONE, 8'h18);
        wr(OFS_CONV_TWO, 8'h80);
        xPos = 12'hA5C;
        yPos = 12'h3B1;
        touched = 1'b1;
        wait_drive(1'b0, 1'b1);
        wait_drive(1'b1, 1'b1);
        wait_drive(1'b1, 1'b0);
        wait_drive(1'b0, 1'b1);
        touched = 1'b0;
        repeat (3000) @(negedge core_clk);
        chk({11'h0, panel.xDrive | panel.yDrive}, 12'h000);
        rdc(OFS_RES_X_HI, 8'h0A);
        rdc(OFS_RES_X_LO, 8'h5C);
        rdc(OFS_RES_Y_HI, 8'h03);
        rdc(OFS_RES_Y_LO, 8'hB1);
        wr(OFS_CONV_ONE, 8'h38);
        touched = 1'b1;
        wait_drive(1'b1, 1'b1);
        wait_drive(1'b1, 1'b0);
        touched = 1'b0;
        rdc(OFS_RES_X_LO, 8'hA5);
    endtask
    task automatic t_host;
        wr(OFS_PAGE, PAGE_ZERO);
        wr(OFS_PIN_ONE, {2'b00, PIN_FN_IRQ, 2'b00});
        wr(OFS_PAGE, PAGE_THREE);
        wr(OFS_CONV_TWO, 8'h00);
        touched = 1'b1;
        repeat (600) @(negedge core_clk);
        chk({10'h0, generalPinOneOeN, generalPinTwoOeN}, 12'h001);
        chk({11'h0, panel.yDrive}, 12'h000);
        for (int k = 0; k < 3; k++) begin
            wr(OFS_CONV_TWO, {6'h00, k[1:0]});
            chk({11'h0, generalPinOne}, {11'h0, k == 1});
        end
        wr(OFS_CONV_TWO, {2'b00, SCAN_XY, IRQ_PEN});
        wait_drive(1'b0, 1'b1);
        wr(OFS_CONV_ONE, 8'h98);
        repeat (100) @(negedge core_clk);
        chk({9'h0, panel.xDrive, panel.yDrive, panel.sarPower}, 12'h000);
        touched = 1'b0;
        wr(OFS_CONV_ONE, 8'h18);
        wr(OFS_CONV_TWO, 8'h00);
        wr(OFS_PRE_SENSE, 8'h80);
        touched = 1'b1;
        repeat (600) @(negedge core_clk);
        chk({11'h0, generalPinOne}, 12'h001);
    endtask
    initial begin
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        t_regs();
        t_self();
        t_host();
        conclude();
    end
endmodule
bind tps_sequencer tps_sequencer_sva i_tps_sequencer_sva (
    .core_clk(core_clk), .sys_rst(sys_rst), .spiCsN(spiCsN),
    .spiMisoOeN(spiMisoOeN), .panel(panel),
    .generalPinOne(generalPinOne), .generalPinOneOeN(generalPinOneOeN),
    .generalPinTwo(generalPinTwo), .generalPinTwoOeN(generalPinTwoOeN));
